/* File: core/sms_pkg.sv */
/*
  Constants for the supply mode sequencer: state codes, register defaults,
  register offsets and timing figures.
  Assumes a 50 MHz system clock.
*/
package sms_pkg;
  localparam int CLK_MHZ = 50;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int WAKE_TO_ACTIVE_TYP_US = 180;
  localparam int WAKE_TO_ACTIVE_MAX_US = 300;
  localparam int WAKE_CYCLES = WAKE_TO_ACTIVE_TYP_US * CLK_MHZ;
  localparam int WAKE_MAX_CYCLES = WAKE_TO_ACTIVE_MAX_US * CLK_MHZ;
  localparam int SPREAD_AVG_KHZ = 2000;
  localparam int SPREAD_MIN_KHZ = 800;
  localparam int SPREAD_MAX_KHZ = 4000;
  // Half periods of the switching clock, in system cycles (max time rounds down)
  localparam int HALF_MIN_CYC = (CLK_MHZ * 1000) / (2 * SPREAD_MAX_KHZ);
  localparam int HALF_MAX_CYC = (CLK_MHZ * 1000) / (2 * SPREAD_MIN_KHZ);
  localparam int HALF_AVG_CYC = (CLK_MHZ * 1000) / (2 * SPREAD_AVG_KHZ);
  // ----------------------------------------
  // Power state field values
  // ----------------------------------------
  localparam logic [1:0] PSEL_ACTIVE = 2'h0;
  localparam logic [1:0] PSEL_STARTUP = 2'h1;
  localparam logic [1:0] PSEL_LOWPWR = 2'h2;
  localparam logic [1:0] PSEL_SHUTDOWN = 2'h3;
  // ----------------------------------------
  // Register map and defaults
  // ----------------------------------------
  localparam logic [3:0] ADDR_PWR = 4'h0;
  localparam logic [3:0] ADDR_OUTEN = 4'h1;
  localparam logic [3:0] ADDR_BOOST = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam int PWR_W = 2;
  localparam int OUTS = 3;
  localparam int LVL_W = 4;
  localparam logic [LVL_W-1:0] BOOST_LVL_RST = 4'hB;
  localparam logic [OUTS-1:0] OUTEN_RST = 3'h0;
  localparam int RAIL_BASE_V = 13;
  typedef enum logic [1:0] {
    SMS_OFF = 2'b00,
    SMS_START = 2'b01,
    SMS_ACT = 2'b11,
    SMS_LOW = 2'b10
  } sms_state_e;
endpackage

/* File: core/supply_mode_sequencer.sv */
/*
  Power mode sequencer: shutdown, startup, active and low power, with the
  register file, output enables and hysteretic boost control.
  Assumes io_supply_level and the comparator input are synchronous to clk_sys,
  and that analog_supply low means the part is unpowered.
*/
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
module supply_mode_sequencer #(
  parameter int WAKE_CYC = sms_pkg::WAKE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic analog_supply,
  input wire logic io_supply_level,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic railBelowRef,
  input wire logic railAboveRef,
  output logic [3:0] boostLevel,
  output logic [4:0] railTargetVolts,
  output logic boostEnable,
  output logic boostSwitchClk,
  output logic [2:0] outEnable,
  output logic [2:0] outHighZ,
  output logic serialReset,
  output logic serialEnable,
  output logic [1:0] powerState
);
  sms_pkg::sms_state_e state_r;
  sms_pkg::sms_state_e state_nxt;
  logic ioPrev_r;
  logic [31:0] wakeCnt_r;
  logic [1:0] pwrField_r;
  logic [2:0] outEn_r;
  logic [3:0] lvl_r;
  logic switching_r;
  logic swClk_r;
  logic [7:0] halfCnt_r;
  logic [15:0] lfsr_r;
  logic [7:0] halfLen;
  logic porPulse;
  logic shutdownNow;
  logic cmdWr;
  logic cmdStartup;
  logic cmdLow;
  logic cmdActive;
  logic regsClear;

  // ----------------------------------------
  // Reset sources
  // ----------------------------------------
  // Edge detect: a held-high supply retriggers the reset only after rst or after analog_supply drops
  assign porPulse = io_supply_level && !ioPrev_r;
  assign shutdownNow = !io_supply_level || !analog_supply;
  assign cmdWr = regWr && regAddr == sms_pkg::ADDR_PWR;
  assign cmdStartup = cmdWr && regWdata[1:0] == sms_pkg::PSEL_STARTUP;
  assign cmdLow = cmdWr && regWdata[1:0] == sms_pkg::PSEL_LOWPWR;
  assign cmdActive = cmdWr && regWdata[1:0] == sms_pkg::PSEL_ACTIVE;
  // Any path into startup clears the register file
  assign regsClear = rst || shutdownNow || state_nxt == sms_pkg::SMS_START;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ioPrev_r <= 1'b0;
    end else if (!analog_supply) begin
      ioPrev_r <= 1'b0;
    end else begin
      ioPrev_r <= io_supply_level;
    end
  end

  // ----------------------------------------
  // Mode state machine
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      sms_pkg::SMS_OFF: begin
        if (porPulse) begin
          state_nxt = sms_pkg::SMS_START;
        end
      end
      sms_pkg::SMS_START: begin
        if (wakeCnt_r >= WAKE_CYC - 1) begin
          state_nxt = sms_pkg::SMS_ACT;
        end
      end
      sms_pkg::SMS_ACT: begin
        if (cmdStartup) begin
          state_nxt = sms_pkg::SMS_START;
        end else if (cmdLow) begin
          state_nxt = sms_pkg::SMS_LOW;
        end
      end
      sms_pkg::SMS_LOW: begin
        if (cmdStartup) begin
          state_nxt = sms_pkg::SMS_START;
        end else if (cmdActive) begin
          state_nxt = sms_pkg::SMS_ACT;
        end
      end
      default: state_nxt = sms_pkg::SMS_OFF;
    endcase
    // Other commands fall through unchanged
    if (shutdownNow) begin
      state_nxt = sms_pkg::SMS_OFF;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= sms_pkg::SMS_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || state_r != sms_pkg::SMS_START || state_nxt != sms_pkg::SMS_START) begin
      wakeCnt_r <= 32'h0;
    end else begin
      wakeCnt_r <= wakeCnt_r + 32'h1;
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (regsClear) begin
      outEn_r <= sms_pkg::OUTEN_RST;
      lvl_r <= sms_pkg::BOOST_LVL_RST;
    end else if (regWr && state_r != sms_pkg::SMS_OFF) begin
      // Writes held in low power; cleared there only by rst, a startup command or supply loss
      if (regAddr == sms_pkg::ADDR_OUTEN) begin
        outEn_r <= regWdata[2:0];
      end
      if (regAddr == sms_pkg::ADDR_BOOST) begin
        lvl_r <= regWdata[3:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    case (state_nxt)
      sms_pkg::SMS_START: pwrField_r <= sms_pkg::PSEL_STARTUP;
      sms_pkg::SMS_ACT: pwrField_r <= sms_pkg::PSEL_ACTIVE;
      sms_pkg::SMS_LOW: pwrField_r <= sms_pkg::PSEL_LOWPWR;
      default: pwrField_r <= sms_pkg::PSEL_SHUTDOWN;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      regRdata <= 8'h0;
    end else if (regRd) begin
      case (regAddr)
        sms_pkg::ADDR_PWR: regRdata <= {6'h0, pwrField_r};
        sms_pkg::ADDR_OUTEN: regRdata <= {5'h0, outEn_r};
        sms_pkg::ADDR_BOOST: regRdata <= {4'h0, lvl_r};
        sms_pkg::ADDR_STATUS: regRdata <= {5'h0, switching_r, boostEnable, serialEnable};
        default: regRdata <= 8'h0;
      endcase
    end else begin
      regRdata <= 8'h0;
    end
  end

  // ----------------------------------------
  // Block enables
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      boostEnable <= 1'b0;
      serialEnable <= 1'b0;
      serialReset <= 1'b1;
      outEnable <= 3'h0;
    end else begin
      boostEnable <= state_nxt == sms_pkg::SMS_START || state_nxt == sms_pkg::SMS_ACT;
      serialEnable <= state_nxt != sms_pkg::SMS_OFF;
      serialReset <= porPulse || shutdownNow;
      outEnable <= (state_nxt == sms_pkg::SMS_ACT && !regsClear) ? outEn_r : 3'h0;
    end
  end

  assign outHighZ = ~outEnable;
  assign boostLevel = lvl_r;
  assign railTargetVolts = 5'(sms_pkg::RAIL_BASE_V) + {1'b0, lvl_r};
  assign powerState = pwrField_r;

  // ----------------------------------------
  // Hysteretic boost and spread clock
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst || !boostEnable) begin
      switching_r <= 1'b0;
    end else if (railBelowRef) begin
      switching_r <= 1'b1;
    end else if (railAboveRef) begin
      switching_r <= 1'b0;
    end
  end

  // Random half period in [min,min+15]; average near the 2 MHz point
  assign halfLen = 8'(sms_pkg::HALF_MIN_CYC) + {4'h0, lfsr_r[3:0]} % 8'(sms_pkg::HALF_MAX_CYC - sms_pkg::HALF_MIN_CYC + 1);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lfsr_r <= 16'hACE1;
      halfCnt_r <= 8'h0;
      swClk_r <= 1'b0;
    end else if (!switching_r) begin
      halfCnt_r <= 8'h0;
      swClk_r <= 1'b0;
    end else if (halfCnt_r == 8'h0) begin
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      halfCnt_r <= halfLen - 8'h1;
      swClk_r <= !swClk_r;
    end else begin
      halfCnt_r <= halfCnt_r - 8'h1;
    end
  end

  assign boostSwitchClk = swClk_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_shutdown_on_low: assert property (@(posedge clk_sys) disable iff (rst)
    !io_supply_level |=> state_r == sms_pkg::SMS_OFF && outEnable == 3'h0)
    else $error("not in shutdown after IO supply low");
  a_startup_outputs: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == sms_pkg::SMS_START |-> outEnable == 3'h0 && boostEnable && serialEnable)
    else $error("startup enables wrong");
  a_por_defaults: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(state_r == sms_pkg::SMS_START) |-> lvl_r == 4'hB && outEn_r == 3'h0)
    else $error("defaults not applied at startup");
  a_startup_exits: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == sms_pkg::SMS_START |-> wakeCnt_r < sms_pkg::WAKE_MAX_CYCLES)
    else $error("startup too long");
  a_low_from_active: assert property (@(posedge clk_sys) disable iff (rst)
    state_r != sms_pkg::SMS_LOW ##1 state_r == sms_pkg::SMS_LOW |->
      $past(state_r) == sms_pkg::SMS_ACT && $past(cmdLow))
    else $error("low power entered illegally");
  a_low_power_off: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == sms_pkg::SMS_LOW |-> !boostEnable && outEnable == 3'h0 && serialEnable)
    else $error("low power enables wrong");
  a_low_keeps_regs: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == sms_pkg::SMS_LOW && !regWr && state_nxt != sms_pkg::SMS_START && !shutdownNow
      |=> $stable(lvl_r) && $stable(outEn_r))
    else $error("registers lost in low power");
  a_power_field: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == sms_pkg::SMS_START ##1 state_r == sms_pkg::SMS_ACT |-> $past(pwrField_r) == 2'h1 && pwrField_r == 2'h0)
    else $error("power field sequence wrong");
  a_por_edge: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == sms_pkg::SMS_ACT && io_supply_level && analog_supply && !cmdWr |=> state_r == sms_pkg::SMS_ACT)
    else $error("spurious leave of active");
  a_hysteresis: assert property (@(posedge clk_sys) disable iff (rst)
    boostEnable && railBelowRef |=> switching_r || !boostEnable)
    else $error("boost not switching below reference");

  // ----------------------------------------
  // Checks: supplies, resets and commands
  // ----------------------------------------
  // Held reset must leave every block off, whatever the supplies do
  a_reset_state: assert property (@(posedge clk_sys)
    rst |=> state_r == sms_pkg::SMS_OFF && outEnable == 3'h0 && !boostEnable && !serialEnable)
    else $error("reset did not force shutdown");
  // Losing the analog supply is treated like a fresh power-up
  a_analog_off: assert property (@(posedge clk_sys) disable iff (rst)
    !analog_supply |=> state_r == sms_pkg::SMS_OFF && outHighZ == 3'h7)
    else $error("analog supply loss not in shutdown");
  a_por_startup: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == sms_pkg::SMS_OFF && porPulse && analog_supply
      |=> state_r == sms_pkg::SMS_START && serialReset)
    else $error("IO supply rise did not start up");
  // A supply that stays high must not restart the part
  a_no_repeat_por: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == sms_pkg::SMS_OFF && ioPrev_r && io_supply_level && analog_supply
      |=> state_r == sms_pkg::SMS_OFF)
    else $error("held IO supply retriggered reset");
  // No register setting survives shutdown; writes there are refused
  a_regs_lost: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == sms_pkg::SMS_OFF |-> lvl_r == sms_pkg::BOOST_LVL_RST && outEn_r == sms_pkg::OUTEN_RST)
    else $error("registers kept in shutdown");
  a_startup_field: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == sms_pkg::SMS_START |-> pwrField_r == sms_pkg::PSEL_STARTUP)
    else $error("power field wrong in startup");
  a_startup_cmd: assert property (@(posedge clk_sys) disable iff (rst)
    (state_r == sms_pkg::SMS_ACT || state_r == sms_pkg::SMS_LOW) && cmdStartup && !shutdownNow
      |=> state_r == sms_pkg::SMS_START && lvl_r == sms_pkg::BOOST_LVL_RST
        && outEn_r == sms_pkg::OUTEN_RST && outEnable == 3'h0)
    else $error("startup command did not reset");
  a_low_to_active: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == sms_pkg::SMS_LOW && cmdActive && !shutdownNow |=> state_r == sms_pkg::SMS_ACT)
    else $error("low power did not return to active");
  // Refused commands must not disturb state or stored settings
  a_illegal_ignored: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == sms_pkg::SMS_LOW && cmdWr && !cmdActive && !cmdStartup && !shutdownNow
      |=> state_r == sms_pkg::SMS_LOW && $stable(lvl_r) && $stable(outEn_r))
    else $error("illegal mode command acted on");
  // Outputs lag the enable register by one cycle in active mode
  a_active_follows: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == sms_pkg::SMS_ACT && state_nxt == sms_pkg::SMS_ACT && !regsClear
      |=> outEnable == $past(outEn_r))
    else $error("outputs do not follow enables");

  // ----------------------------------------
  // Checks: boost control
  // ----------------------------------------
  a_switch_stops: assert property (@(posedge clk_sys) disable iff (rst)
    boostEnable && switching_r && railAboveRef && !railBelowRef |=> !switching_r)
    else $error("boost kept switching above reference");
  // A stopped converter must leave its switch open
  a_clock_idle: assert property (@(posedge clk_sys) disable iff (rst)
    !switching_r |=> !swClk_r)
    else $error("switching clock running while idle");
  a_half_bound: assert property (@(posedge clk_sys) disable iff (rst)
    switching_r |-> halfCnt_r < 8'(sms_pkg::HALF_MAX_CYC))
    else $error("switching half period too long");
endmodule

/* File: sim/sms_bus_master.sv */
/*
  Register bus master model standing in for the serial link master.
  Assumes the sequencer samples strobes on the rising edge of clk_sys.
*/
`timescale 1ns/10ps
module sms_bus_master (
  input wire logic clk_sys,
  input wire logic [7:0] regRdata,
  output logic [3:0] regAddr,
  output logic [7:0] regWdata,
  output logic regWr,
  output logic regRd
);
  initial begin
    regAddr = 4'h0;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
  end
  // Mode codes: 0 active, 1 startup, 2 low power
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
    // Released data must not keep showing the last value
    regWdata <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
endmodule

/* File: sim/tb.sv */
/*
  Self-checking bench for the supply mode sequencer.
  Assumes a shortened wake count of 20 cycles.
*/
`timescale 1ns/10ps
module tb;
  localparam int WAKE = 20;
  localparam int LIM = WAKE * sms_pkg::WAKE_TO_ACTIVE_MAX_US / sms_pkg::WAKE_TO_ACTIVE_TYP_US;
  logic clk_sys, rst, analog_supply, io_supply_level, regWr, regRd, railBelowRef, railAboveRef;
  logic boostEnable, boostSwitchClk, serialReset, serialEnable;
  logic [3:0] regAddr, boostLevel;
  logic [7:0] regWdata, regRdata, rdv;
  logic [4:0] railTargetVolts;
  logic [2:0] outEnable, outHighZ;
  logic [1:0] powerState;
  int fail_count = 0;
  int n_compared = 0;
  int n;
  supply_mode_sequencer #(.WAKE_CYC(WAKE)) dut (.clk_sys(clk_sys), .rst(rst), .analog_supply(analog_supply),
    .io_supply_level(io_supply_level), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .railBelowRef(railBelowRef), .railAboveRef(railAboveRef), .boostLevel(boostLevel),
    .railTargetVolts(railTargetVolts), .boostEnable(boostEnable), .boostSwitchClk(boostSwitchClk),
    .outEnable(outEnable), .outHighZ(outHighZ), .serialReset(serialReset), .serialEnable(serialEnable),
    .powerState(powerState));
  sms_bus_master master (.clk_sys(clk_sys), .regRdata(regRdata), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic step(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask
  task automatic complete_run;
    if (fail_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic mode(input logic [1:0] ps, input logic be, input logic [2:0] oe);
    chk("powerState", {6'h0, ps}, {6'h0, powerState});
    chk("boostEnable", {7'h0, be}, {7'h0, boostEnable});
    chk("outEnable", {5'h0, oe}, {5'h0, outEnable});
    chk("outHighZ", {5'h0, ~oe}, {5'h0, outHighZ});
  endtask
  // Bounded wait; running out ends the run as a failure
  task automatic waitState(input logic [1:0] ps, input int lim);
    for (n = 0; n < lim && powerState !== ps; n++) step(1);
    if (powerState !== ps) begin
      fail_count++;
      $display("CHECK FAILED powerState expected %h seen %h", ps, powerState);
      complete_run();
    end
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    analog_supply = 1'b1;
    io_supply_level = 1'b0;
    railBelowRef = 1'b0;
    railAboveRef = 1'b1;
    step(2);
    rst <= 1'b0;
    step(2);
    mode(2'h3, 1'b0, 3'h0);
    master.wr(sms_pkg::ADDR_OUTEN, 8'h07);
    io_supply_level <= 1'b1;
    step(1);
    mode(2'h1, 1'b1, 3'h0);
    chk("serialReset", 8'h01, {7'h0, serialReset});
    master.rd(sms_pkg::ADDR_BOOST, rdv);
    chk("boostLevel", 8'h0B, rdv);
    chk("boostLevelPort", 8'h0B, {4'h0, boostLevel});
    chk("serialReset", 8'h00, {7'h0, serialReset});
    chk("railTargetVolts", 8'd24, {3'h0, railTargetVolts});
    waitState(2'h0, LIM);
    chk("serialEnable", 8'h01, {7'h0, serialEnable});
    mode(2'h0, 1'b1, 3'h0);
    master.wr(sms_pkg::ADDR_OUTEN, 8'h05);
    step(2);
    mode(2'h0, 1'b1, 3'h5);
    for (int i = 0; i < 16; i += 5) begin
      master.wr(sms_pkg::ADDR_BOOST, 8'(i));
      step(1);
      chk("railTargetVolts", 8'(i + sms_pkg::RAIL_BASE_V), {3'h0, railTargetVolts});
    end
    master.wr(sms_pkg::ADDR_PWR, 8'h02);
    step(2);
    mode(2'h2, 1'b0, 3'h0);
    master.wr(sms_pkg::ADDR_PWR, 8'h02);
    master.wr(sms_pkg::ADDR_PWR, 8'h03);
    step(2);
    mode(2'h2, 1'b0, 3'h0);
    master.rd(sms_pkg::ADDR_OUTEN, rdv);
    chk("outEnableReg", 8'h05, rdv);
    master.rd(sms_pkg::ADDR_BOOST, rdv);
    chk("boostLevel", 8'h0F, rdv);
    master.wr(sms_pkg::ADDR_PWR, 8'h00);
    step(2);
    mode(2'h0, 1'b1, 3'h5);
    railBelowRef <= 1'b1;
    railAboveRef <= 1'b0;
    for (n = 0; n < 100 && boostSwitchClk !== 1'b1; n++) step(1);
    for (n = 0; n < 40 && boostSwitchClk === 1'b1; n++) step(1);
    chk("switchHalfPeriod", 8'h01, {7'h0, n >= sms_pkg::HALF_MIN_CYC && n <= sms_pkg::HALF_MAX_CYC});
    master.rd(sms_pkg::ADDR_STATUS, rdv);
    chk("status", 8'h07, rdv);
    railBelowRef <= 1'b0;
    railAboveRef <= 1'b1;
    step(2 * sms_pkg::HALF_MAX_CYC + 2);
    chk("boostSwitchClk", 8'h00, {7'h0, boostSwitchClk});
    master.wr(sms_pkg::ADDR_PWR, 8'h01);
    step(1);
    mode(2'h1, 1'b1, 3'h0);
    master.rd(sms_pkg::ADDR_BOOST, rdv);
    chk("boostLevel", 8'h0B, rdv);
    waitState(2'h0, LIM);
    io_supply_level <= 1'b0;
    step(1);
    mode(2'h3, 1'b0, 3'h0);
    chk("serialReset", 8'h01, {7'h0, serialReset});
    io_supply_level <= 1'b1;
    waitState(2'h0, LIM + 2);
    master.rd(sms_pkg::ADDR_OUTEN, rdv);
    chk("outEnableReg", 8'h00, rdv);
    analog_supply <= 1'b0;
    step(1);
    mode(2'h3, 1'b0, 3'h0);
    complete_run();
  end
endmodule
